// File: design/spmc_pkg.sv
/*
  Shared constants, types and the identification code of the scratchpad
  memory command logic.
  Assumes a slot decoder on the same clock that reports bus events.
*/
package spmc_pkg;

  // ----------------------------------------------------------------------
  // Commands and layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ROM  = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM = 8'h55;
  localparam logic [7:0] CMD_SKIP_ROM  = 8'hCC;
  localparam logic [7:0] CMD_WR_SCR    = 8'h0F;
  localparam logic [7:0] CMD_RD_SCR    = 8'hAA;
  localparam logic [7:0] CMD_COPY_SCR  = 8'h55;
  localparam int         PAGE_BYTES    = 32;
  localparam int         ES_PF_BIT     = 5;
  localparam int         ES_OF_BIT     = 6;
  localparam int         ES_AA_BIT     = 7;
  localparam logic [5:0] POS_END       = 6'h20;
  localparam logic [6:0] ROM_BITS      = 7'h40;
  localparam logic [6:0] ROM_BYTES     = 7'h08;
  localparam logic [6:0] HDR_BYTES     = 7'h03;
  localparam logic [7:0] CRC_TAPS      = 8'h8C;
  localparam logic [7:0] ALL_ONES      = 8'hFF;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam int         DEF_PAGES     = 16;
  localparam int         FIFO_DEPTH    = 16;

  // Family code and serial number are arbitrary values.
  localparam logic [7:0]  FAMILY_CODE  = 8'h5A;
  localparam logic [47:0] SERIAL_NUM   = 48'h0123_4567_89AB;

  // Shift a run of bits through the generator, lowest bit first.
  function automatic logic [7:0] crc8_bits(input logic [63:0] d,
                                           input int n);
    logic [7:0] c;
    logic       fb;
    c = 8'h00; // [RL5]
    for (int i = 0; i < n; i++) begin
      fb = c[0] ^ d[i]; // [RL4]
      c  = c >> 1;
      if (fb) begin
        c = c ^ CRC_TAPS;
      end
    end
    return c;
  endfunction : crc8_bits

  localparam logic [55:0] ROM_BODY = {SERIAL_NUM, FAMILY_CODE};
  localparam logic [63:0] ROM_CODE =
    {crc8_bits({8'h00, ROM_BODY}, 56), ROM_BODY};

  typedef enum logic [3:0] {
    ST_ROM_CMD, ST_MATCH, ST_READ_ROM, ST_MEM_CMD, ST_WS_ADDR, ST_WS_DATA,
    ST_RS_SEND, ST_CP_AUTH, ST_COPY, ST_COPY_DONE, ST_WAIT_RST
  } spmc_state_t;

  // Slot events from the bit-level decoder.
  typedef struct packed {
    logic rst;
    logic wr;
    logic bit_val;
    logic rd;
  } spmc_slot_t;

endpackage : spmc_pkg

// File: design/spmc_top.sv
/*
  Byte FIFO and the command interpreter of the scratchpad memory device.
  Assumes slot events arrive on mclk_i, one event per cycle at most.
*/
// What this block does
// (RL1) Bytes and commands move lowest bit first in both directions.
// (RL2) Memory commands are refused until a ROM command sequence succeeded.
// (RL3) A 64-bit code: family byte, 48-bit serial, then CRC byte.
// (RL4) The code CRC uses polynomial x8 + x5 + x4 + 1.
// (RL5) CRC starts at zero and takes family bits first, then serial bits.
// (RL6) Receiver shifts in the CRC too and expects all zeros.
// (RL7) Memory is 32-byte pages, 4 or 16 of them, plus a scratchpad.
// (RL8) Memory is written only by copying the scratchpad.
// (RL9) Two target address bytes, low first, then an offset/status byte.
// (RL10) Target bits 4..0 pick one of 32 bytes in a page.
// (RL11) Status is read only: offset, partial, overflow, authorised bits.
// (RL12) Write command takes two address bytes, then data at the offset.
// (RL13) The ending offset is the byte where the master stopped writing.
// (RL14) Ending offset stops at 31; excess data sets overflow, is dropped.
// (RL15) An unfinished byte without overflow sets the partial flag.
// (RL16) Read command sends both address bytes, status, then scratchpad.
// (RL17) Reading beyond the scratchpad end returns all ones.
// (RL18) Copy needs the three register bytes as key, then sets authorised.
// (RL19) Only a write command clears the authorised flag.
// (RL20) Skip command opens memory commands without the code.
// (RL21) A bus reset aborts any command except a running copy.
`timescale 1ns/1ns

// ------------------------------------------------------------------------
// Byte FIFO
// ------------------------------------------------------------------------
module spmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("FIFO depth must be a power of two of at least 2.");
    end
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Honest full and empty from the fill count.
  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH)) && !flush_i;
  assign out_valid_o = (cnt_r != '0) && !flush_i;
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointers and count; a flush empties the queue at once.
  always_ff @(posedge mclk_i) begin
    if (rst_i || flush_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= push ? wp_r + 1'b1 : wp_r;
      rp_r  <= pop ? rp_r + 1'b1 : rp_r;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage words.
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
endmodule : spmc_fifo

// ------------------------------------------------------------------------
// Command interpreter
// ------------------------------------------------------------------------
module spmc_top #(
  parameter int NUM_PAGES = spmc_pkg::DEF_PAGES
) (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // Slot events from the bit decoder
  input  wire spmc_pkg::spmc_slot_t  slot_i,
  // Answer bit for each read slot
  output logic                       rd_bit_o,
  output logic                       rd_valid_o,
  // Memory inspection port
  input  wire logic [8:0]            mem_rd_addr_i,
  output logic      [7:0]            mem_rd_data_o,
  // Status
  output logic                       mem_access_o,
  output logic                       copy_busy_o
);
  import spmc_pkg::*;

  localparam int PB = $clog2(NUM_PAGES);

  initial begin
    if (NUM_PAGES != 4 && NUM_PAGES != 16) begin
      $error("Page count must be 4 or 16.");
    end
  end

  typedef struct packed {
    spmc_state_t st;
    logic [7:0]  rx_sh;
    logic [2:0]  rx_cnt;
    logic [7:0]  tx_sh;
    logic [3:0]  tx_cnt;
    logic [6:0]  idx;
    logic [5:0]  pos;
    logic        mism;
    logic [7:0]  ta_lo;
    logic [7:0]  ta_hi;
    logic [4:0]  e_off;
    logic        pf;
    logic        of;
    logic        aa;
    logic        rd_bit;
    logic        rd_valid;
  } spmc_regs_t;

  spmc_regs_t  s_r;
  spmc_regs_t  s_nxt;
  logic [7:0]  scr_r [PAGE_BYTES];
  logic [7:0]  mem_r [NUM_PAGES*PAGE_BYTES];
  logic        byte_done;
  logic [7:0]  rx_byte;
  logic [7:0]  es;
  logic        push_valid;
  logic        push_ready;
  logic [7:0]  push_data;
  logic        pop_valid;
  logic        pop_ready;
  logic [7:0]  pop_data;
  logic        scr_we;
  logic [4:0]  scr_wa;
  logic        mem_we;
  logic        ws_go;
  logic [PB-1:0] page_idx;

  // Page number is target bit 5 and up; with 16 pages it spans both address bytes, with 4 only the low one.
  assign page_idx = PB'({s_r.ta_hi, s_r.ta_lo} >> 5); // [RL7] [RL9]
  // Incoming bits fill the byte from the top, so bit 0 comes first.
  assign rx_byte   = {slot_i.bit_val, s_r.rx_sh[7:1]}; // [RL1]
  assign byte_done = slot_i.wr && (s_r.rx_cnt == 3'h7);
  assign es = {s_r.aa, s_r.of, s_r.pf, s_r.e_off}; // [RL9] [RL11]
  assign ws_go = (s_r.st == ST_MEM_CMD) && byte_done &&
                 (rx_byte == CMD_WR_SCR);
  assign pop_ready = slot_i.rd && (s_r.tx_cnt == 4'h0);

  spmc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .flush_i     (slot_i.rst && (s_r.st != ST_COPY)),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  // Next state of the interpreter and of both shifters.
  always_comb begin
    s_nxt      = s_r;
    push_valid = 1'b0;
    push_data  = ALL_ONES;
    scr_we     = 1'b0;
    scr_wa     = s_r.pos[4:0];
    mem_we     = 1'b0;
    s_nxt.rd_valid = 1'b0;
    if (slot_i.wr) begin
      s_nxt.rx_sh  = rx_byte;
      s_nxt.rx_cnt = s_r.rx_cnt + 3'h1;
    end
    // Outgoing bytes leave lowest bit first; empty queue answers one, but a finished copy answers zero.
    if (slot_i.rd) begin
      s_nxt.rd_valid = 1'b1;
      if (s_r.st == ST_COPY_DONE) begin
        s_nxt.rd_bit = 1'b0;
      end else if (s_r.tx_cnt != 4'h0) begin
        s_nxt.rd_bit = s_r.tx_sh[0]; // [RL1]
        s_nxt.tx_sh  = s_r.tx_sh >> 1;
        s_nxt.tx_cnt = s_r.tx_cnt - 4'h1;
      end else if (pop_valid) begin
        s_nxt.rd_bit = pop_data[0];
        s_nxt.tx_sh  = pop_data >> 1;
        s_nxt.tx_cnt = 4'h7;
      end else begin
        s_nxt.rd_bit = 1'b1;
      end
    end
    case (s_r.st)
      ST_ROM_CMD: begin
        if (byte_done) begin
          s_nxt.idx  = '0;
          s_nxt.mism = 1'b0;
          case (rx_byte)
            CMD_READ_ROM:  s_nxt.st = ST_READ_ROM;
            CMD_MATCH_ROM: s_nxt.st = ST_MATCH;
            CMD_SKIP_ROM:  s_nxt.st = ST_MEM_CMD; // [RL20]
            default:       s_nxt.st = ST_WAIT_RST;
          endcase
        end
      end
      ST_MATCH: begin
        if (slot_i.wr) begin
          s_nxt.idx  = s_r.idx + 7'h1;
          s_nxt.mism = s_r.mism | (slot_i.bit_val != ROM_CODE[s_r.idx[5:0]]);
          if (s_r.idx == ROM_BITS - 7'h1) begin
            s_nxt.st     = s_nxt.mism ? ST_WAIT_RST : ST_MEM_CMD; // [RL2]
            s_nxt.rx_cnt = 3'h0;
          end
        end
      end
      ST_READ_ROM: begin
        push_valid = 1'b1;
        push_data  = ROM_CODE[s_r.idx[2:0]*8 +: 8]; // [RL3]
        if (push_ready) begin
          s_nxt.idx = s_r.idx + 7'h1;
          if (s_r.idx == ROM_BYTES - 7'h1) begin
            s_nxt.st = ST_MEM_CMD;
          end
        end
      end
      ST_MEM_CMD: begin
        if (byte_done) begin
          s_nxt.idx  = '0;
          s_nxt.mism = 1'b0;
          case (rx_byte)
            CMD_WR_SCR: begin
              s_nxt.st = ST_WS_ADDR;
              s_nxt.aa = 1'b0; // [RL19]
              s_nxt.of = 1'b0;
              s_nxt.pf = 1'b0;
            end
            CMD_RD_SCR:   s_nxt.st = ST_RS_SEND;
            CMD_COPY_SCR: s_nxt.st = ST_CP_AUTH;
            default:      s_nxt.st = ST_WAIT_RST;
          endcase
        end
      end
      ST_WS_ADDR: begin
        if (byte_done) begin
          s_nxt.idx = s_r.idx + 7'h1;
          if (s_r.idx == 7'h0) begin
            s_nxt.ta_lo = rx_byte; // [RL12]
          end else begin
            s_nxt.ta_hi = rx_byte;
            s_nxt.st    = ST_WS_DATA;
            s_nxt.pos   = {1'b0, s_r.ta_lo[4:0]}; // [RL10]
            s_nxt.e_off = s_r.ta_lo[4:0];
          end
        end
      end
      ST_WS_DATA: begin
        if (byte_done) begin
          if (s_r.pos == POS_END) begin
            s_nxt.of = 1'b1; // [RL14]
          end else begin
            scr_we      = 1'b1; // [RL12]
            s_nxt.e_off = s_r.pos[4:0]; // [RL13]
            s_nxt.pos   = s_r.pos + 6'h1;
          end
        end
      end
      ST_RS_SEND: begin
        push_valid = 1'b1;
        if (s_r.idx == 7'h0) begin
          push_data = s_r.ta_lo; // [RL16]
        end else if (s_r.idx == 7'h1) begin
          push_data = s_r.ta_hi;
        end else if (s_r.idx == 7'h2) begin
          push_data = es;
        end else if (s_r.pos != POS_END) begin
          push_data = scr_r[s_r.pos[4:0]];
        end else begin
          push_data = ALL_ONES; // [RL17]
        end
        if (push_ready) begin
          if (s_r.idx < HDR_BYTES) begin
            s_nxt.idx = s_r.idx + 7'h1;
            s_nxt.pos = {1'b0, s_r.ta_lo[4:0]};
          end else if (s_r.pos != POS_END) begin
            s_nxt.pos = s_r.pos + 6'h1;
          end
        end
      end
      ST_CP_AUTH: begin
        if (byte_done) begin
          s_nxt.idx = s_r.idx + 7'h1;
          case (s_r.idx[1:0])
            2'h0:    s_nxt.mism = s_r.mism | (rx_byte != s_r.ta_lo);
            2'h1:    s_nxt.mism = s_r.mism | (rx_byte != s_r.ta_hi);
            default: s_nxt.mism = s_r.mism | (rx_byte != es);
          endcase
          if (s_r.idx == HDR_BYTES - 7'h1) begin
            s_nxt.st  = s_nxt.mism ? ST_WAIT_RST : ST_COPY; // [RL18]
            s_nxt.aa  = s_r.aa | !s_nxt.mism;
            s_nxt.pos = {1'b0, s_r.ta_lo[4:0]};
          end
        end
      end
      ST_COPY: begin
        mem_we    = 1'b1; // [RL8]
        s_nxt.pos = s_r.pos + 6'h1;
        if (s_r.pos[4:0] == s_r.e_off || s_r.pos[4:0] == 5'h1F) begin
          s_nxt.st = ST_COPY_DONE;
        end
      end
      ST_COPY_DONE: begin
      end
      ST_WAIT_RST: begin
      end
      default: s_nxt.st = ST_WAIT_RST;
    endcase
    // Bus reset ends any command but a copy in progress.
    if (slot_i.rst && s_r.st != ST_COPY) begin // [RL21]
      if (s_r.st == ST_WS_DATA && s_r.rx_cnt != 3'h0 && !s_r.of) begin
        s_nxt.pf    = 1'b1; // [RL15]
        s_nxt.e_off = s_r.pos[4:0];
      end
      s_nxt.st     = ST_ROM_CMD;
      s_nxt.rx_cnt = 3'h0;
      s_nxt.tx_cnt = 4'h0;
    end
  end

  // State register.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_r <= '{st: ST_ROM_CMD, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Scratchpad, memory page and inspection read.
  always_ff @(posedge mclk_i) begin
    if (scr_we) begin
      scr_r[scr_wa] <= rx_byte;
    end
    if (mem_we) begin // [RL7]
      mem_r[{page_idx, s_r.pos[4:0]}] <= scr_r[s_r.pos[4:0]];
    end
    if (rst_i) begin
      mem_rd_data_o <= RST_BYTE;
    end else begin
      mem_rd_data_o <= mem_r[mem_rd_addr_i[PB+4:0]];
    end
  end

  assign rd_bit_o     = s_r.rd_bit;
  assign rd_valid_o   = s_r.rd_valid;
  assign mem_access_o = (s_r.st != ST_ROM_CMD) && (s_r.st != ST_MATCH) &&
                        (s_r.st != ST_READ_ROM) && (s_r.st != ST_WAIT_RST);
  assign copy_busy_o  = (s_r.st == ST_COPY);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence seq_rs_cmd;
    s_r.st == ST_MEM_CMD && byte_done && rx_byte == CMD_RD_SCR &&
      !slot_i.rst;
  endsequence

  sequence seq_skip;
    s_r.st == ST_ROM_CMD && byte_done && rx_byte == CMD_SKIP_ROM &&
      !slot_i.rst;
  endsequence

  a_skip_opens: assert property (seq_skip |=> mem_access_o) // [RL20]
    else $error("Skip command did not open memory commands.");
  a_mem_gated: assert property (
    s_r.st != ST_WS_ADDR ##1 s_r.st == ST_WS_ADDR |-> $past(ws_go)) // [RL2]
    else $error("Write command taken outside memory phase.");
  a_rs_header: assert property (seq_rs_cmd |=> push_valid && // [RL16]
    push_data == s_r.ta_lo)
    else $error("Read command did not start with low address.");
  a_ones_past: assert property (s_r.st == ST_RS_SEND && // [RL17]
    s_r.idx == HDR_BYTES && s_r.pos == POS_END |-> push_data == ALL_ONES)
    else $error("Read past scratchpad end not all ones.");
  a_ovf_set: assert property (s_r.st == ST_WS_DATA && byte_done && // [RL14]
    s_r.pos == POS_END && !slot_i.rst |=> s_r.of && !scr_we)
    else $error("Overflow flag not set on excess data.");
  a_part_flag: assert property (s_r.st == ST_WS_DATA && slot_i.rst && // [RL15]
    s_r.rx_cnt != 3'h0 && !s_r.of |=> s_r.pf && s_r.st == ST_ROM_CMD)
    else $error("Partial byte flag not set.");
  a_aa_clear: assert property ($fell(s_r.aa) |-> $past(ws_go)) // [RL19]
    else $error("Authorised flag cleared by other event.");
  a_copy_hold: assert property (copy_busy_o && slot_i.rst |=> // [RL21]
    s_r.st == ST_COPY || s_r.st == ST_COPY_DONE)
    else $error("Bus reset aborted a running copy.");
  a_crc_zero: assert property (crc8_bits(ROM_CODE, 64) == 8'h00) // [RL6]
    else $error("Identification code does not check to zero.");
  a_tx_lsb: assert property (pop_ready && pop_valid && // [RL1]
    s_r.st != ST_COPY_DONE |=> rd_valid_o && rd_bit_o == $past(pop_data[0]))
    else $error("First sent bit is not the lowest.");
endmodule : spmc_top

// File: dv/spmc_master_model.sv
/*
  Behavioural bus master that issues slot events to the command logic.
  Assumes the device answers every read slot exactly one cycle later.
*/
`timescale 1ns/1ns

module spmc_master_model (
  // Clock
  input  wire logic            mclk_i,
  // Slot events towards the device
  output spmc_pkg::spmc_slot_t slot_o,
  // Answer from the device
  input  wire logic            rd_bit_i,
  input  wire logic            rd_valid_i
);
  import spmc_pkg::*;

  int unsigned late_cnt;

  // Idle slots start cleared and no late answers are counted yet.
  initial begin
    slot_o   = '0;
    late_cnt = 0;
  end

  // -----------------------------------------------------------------------
  // Slot drivers
  // -----------------------------------------------------------------------

  // One slot event, launched just after a rising edge.
  task automatic drive(input logic r, input logic w, input logic b,
                       input logic q);
    @(posedge mclk_i);
    slot_o <= '{rst: r, wr: w, bit_val: b, rd: q};
  endtask : drive

  // Idle cycle; the unused data bit toggles so it is never trusted.
  task automatic idle();
    drive(1'b0, 1'b0, ~slot_o.bit_val, 1'b0);
  endtask : idle

  // Reset pulse that opens every transaction.
  task automatic bus_reset();
    drive(1'b1, 1'b0, ~slot_o.bit_val, 1'b0);
    repeat (3) idle();
  endtask : bus_reset

  // Single write slot.
  task automatic put_bit(input logic b);
    drive(1'b0, 1'b1, b, 1'b0);
  endtask : put_bit

  // Whole byte, lowest bit first, then a gap so the answer queue fills.
  task automatic put_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      put_bit(d[i]);
    end
    repeat (2) idle();
  endtask : put_byte

  // Eight read slots, lowest bit first; the answer is taken a cycle later.
  task automatic get_byte(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      drive(1'b0, 1'b0, ~slot_o.bit_val, 1'b1);
      idle();
      #1;
      if (rd_valid_i !== 1'b1) begin
        late_cnt++;
      end
      d[i] = rd_bit_i;
    end
  endtask : get_byte

  // Remainder of the code after all 64 bits; zero means accepted.
  function automatic logic [7:0] crc_rest(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++) begin
      c = (c >> 1) ^ (((c[0] ^ d[i]) == 1'b1) ? 8'h8C : 8'h00);
    end
    return c;
  endfunction : crc_rest

endmodule : spmc_master_model

// File: dv/scratchpad_memory_commands_test.sv
/*
  Self-checking bench for the scratchpad command logic.
  Assumes the bus master model drives every slot event of the device.
*/
`timescale 1ns/1ns

`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module scratchpad_memory_commands_test;
  import spmc_pkg::*;

  logic        mclk;
  logic        rst;
  spmc_slot_t  slot;
  logic        rd_bit;
  logic        rd_valid;
  logic [8:0]  mem_addr;
  logic [7:0]  mem_data;
  logic        mem_access;
  logic        copy_busy;
  logic [63:0] rom;
  logic [7:0]  b;
  int          errors;
  int          n_checks;

  // -----------------------------------------------------------------------
  // Device and master
  // -----------------------------------------------------------------------
  spmc_top #(.NUM_PAGES(16)) i_dut (
    .mclk_i        (mclk),
    .rst_i         (rst),
    .slot_i        (slot),
    .rd_bit_o      (rd_bit),
    .rd_valid_o    (rd_valid),
    .mem_rd_addr_i (mem_addr),
    .mem_rd_data_o (mem_data),
    .mem_access_o  (mem_access),
    .copy_busy_o   (copy_busy)
  );

  spmc_master_model i_master (
    .mclk_i     (mclk),
    .slot_o     (slot),
    .rd_bit_i   (rd_bit),
    .rd_valid_i (rd_valid)
  );

  // Free-running clock of 100 MHz.
  always #5 mclk = ~mclk;

  // -----------------------------------------------------------------------
  // Helper tasks
  // -----------------------------------------------------------------------

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // One line as each test ends.
  task automatic end_test(input string name);
    $display("test %s done, errors so far %0d", name, errors);
  endtask : end_test

  // Reads one byte from the device and compares it.
  task automatic expect_rd(input logic [7:0] e);
    logic [7:0] d;
    i_master.get_byte(d);
    `CHK(d, e)
  endtask : expect_rd

  // Reset pulse, skip command, then one memory command.
  task automatic mem_sess(input logic [7:0] cmd);
    i_master.bus_reset();
    i_master.put_byte(CMD_SKIP_ROM);
    i_master.put_byte(cmd);
  endtask : mem_sess

  // Looks at one memory byte through the inspection port.
  task automatic mem_peek(input logic [8:0] a, input logic [7:0] e);
    @(posedge mclk);
    mem_addr <= a;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(mem_data, e)
  endtask : mem_peek

  // Waits, bounded, until the copy has finished.
  task automatic wait_copy();
    int n;
    n = 0;
    while (copy_busy !== 1'b0 && n < 64) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(copy_busy, 1'b0)
  endtask : wait_copy

  // -----------------------------------------------------------------------
  // Test sequence
  // -----------------------------------------------------------------------

  // Reset for three cycles, then the tests in order.
  initial begin
    mclk     = 1'b0;
    rst      = 1'b1;
    errors   = 0;
    n_checks = 0;
    mem_addr = 9'h000;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK(mem_access, 1'b0)
    `CHK(copy_busy, 1'b0)
    mem_sess(CMD_RD_SCR);
    expect_rd(8'h00);
    expect_rd(8'h00);
    expect_rd(8'h00);
    end_test("register reset");

    i_master.bus_reset();
    i_master.put_byte(CMD_READ_ROM);
    for (int k = 0; k < 8; k++) begin
      i_master.get_byte(b);
      rom[8*k+:8] = b;
    end
    `CHK(rom[7:0], FAMILY_CODE)
    `CHK(rom[55:8], SERIAL_NUM)
    `CHK(i_master.crc_rest(rom), 8'h00)
    end_test("identification code");

    i_master.bus_reset();
    i_master.put_byte(CMD_RD_SCR);
    `CHK(mem_access, 1'b0)
    expect_rd(8'hFF);
    end_test("memory command refused");

    i_master.bus_reset();
    i_master.put_byte(CMD_SKIP_ROM);
    `CHK(mem_access, 1'b1)
    i_master.put_byte(CMD_WR_SCR);
    i_master.put_byte(8'h26);
    i_master.put_byte(8'h00);
    i_master.put_byte(8'hC3);
    i_master.put_byte(8'h5E);
    mem_sess(CMD_RD_SCR);
    expect_rd(8'h26);
    expect_rd(8'h00);
    expect_rd(8'h07);
    expect_rd(8'hC3);
    expect_rd(8'h5E);
    end_test("write and read back");

    mem_sess(CMD_COPY_SCR);
    i_master.put_byte(8'h26);
    i_master.put_byte(8'h00);
    i_master.put_byte(8'h07);
    wait_copy();
    expect_rd(8'h00);
    mem_peek(9'h026, 8'hC3);
    mem_peek(9'h027, 8'h5E);
    mem_sess(CMD_RD_SCR);
    expect_rd(8'h26);
    expect_rd(8'h00);
    expect_rd(8'h87);
    end_test("copy with key");

    mem_sess(CMD_WR_SCR);
    i_master.put_byte(8'h04);
    i_master.put_byte(8'h00);
    i_master.put_byte(8'hA5);
    i_master.put_bit(1'b1);
    i_master.put_bit(1'b0);
    i_master.put_bit(1'b1);
    mem_sess(CMD_RD_SCR);
    expect_rd(8'h04);
    expect_rd(8'h00);
    expect_rd(8'h25);
    expect_rd(8'hA5);
    end_test("partial byte");

    mem_sess(CMD_WR_SCR);
    i_master.put_byte(8'h1E);
    i_master.put_byte(8'h00);
    i_master.put_byte(8'h11);
    i_master.put_byte(8'h22);
    i_master.put_byte(8'h33);
    mem_sess(CMD_RD_SCR);
    expect_rd(8'h1E);
    expect_rd(8'h00);
    expect_rd(8'h5F);
    expect_rd(8'h11);
    expect_rd(8'h22);
    expect_rd(8'hFF);
    expect_rd(8'hFF);
    end_test("overflow");

    // A match with one wrong bit is refused.
    i_master.bus_reset();
    i_master.put_byte(CMD_MATCH_ROM);
    for (int k = 0; k < 64; k++) begin
      i_master.put_bit(rom[k] ^ (k == 9));
    end
    i_master.put_byte(CMD_RD_SCR);
    `CHK(mem_access, 1'b0)
    expect_rd(8'hFF);
    // The right code opens memory; the copy lands in the last page.
    i_master.bus_reset();
    i_master.put_byte(CMD_MATCH_ROM);
    for (int k = 0; k < 64; k++) begin
      i_master.put_bit(rom[k]);
    end
    i_master.put_byte(CMD_WR_SCR);
    `CHK(mem_access, 1'b1)
    i_master.put_byte(8'hE6);
    i_master.put_byte(8'h01);
    i_master.put_byte(8'h3C);
    i_master.put_byte(8'h96);
    mem_sess(CMD_COPY_SCR);
    i_master.put_byte(8'hE6);
    i_master.put_byte(8'h01);
    i_master.put_byte(8'h07);
    wait_copy();
    mem_peek(9'h1E6, 8'h3C);
    mem_peek(9'h1E7, 8'h96);
    end_test("match and last page");

    // A hardware reset in mid-run clears the address registers.
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK(mem_access, 1'b0)
    `CHK(copy_busy, 1'b0)
    mem_sess(CMD_RD_SCR);
    expect_rd(8'h00);
    expect_rd(8'h00);
    expect_rd(8'h00);
    end_test("second reset");

    `CHK(i_master.late_cnt, 0)
    stop_test();
  end

  // Watchdog, about fifteen times the expected length of the tests.
  initial begin
    #200000;
    errors++;
    stop_test();
  end

endmodule : scratchpad_memory_commands_test
